// File: verilog/oam_endpoint_regs.vh
// constants for the oam endpoint frame handler
// assumes a single 200 MHz core clock and plain configuration ports
`ifndef OAM_ENDPOINT_REGS_VH
`define OAM_ENDPOINT_REGS_VH

// ----------------------------------------
// opcodes
// ----------------------------------------
`define OP_LBM      8'h03
`define OP_LBR      8'h02
`define OP_LMM      8'h2b
`define OP_LMR      8'h2a
`define OP_DMM      8'h2f
`define OP_DMR      8'h2e
`define OP_SLM      8'h37
`define OP_SLR      8'h36
`define OP_CCM      8'h01
`define OP_TST      8'h25
`define OP_SAMSEQ   8'h60

// ----------------------------------------
// loop enable bit positions
// ----------------------------------------
`define LOOP_BIT_LB   0
`define LOOP_BIT_LM   1
`define LOOP_BIT_DM   2
`define LOOP_BIT_SL   3
`define LOOP_BIT_NON  4

// ----------------------------------------
// classes, widths, fifo, reset values
// ----------------------------------------
`define CLASS_OWN        3'h7
`define CLASS_SETS       32
`define CNT_W            32
`define SEQ_W            32
`define CNT_ZERO         32'h0000_0000
`define CNT_ONE          32'h0000_0001
`define FIFO_DEPTH       8
`define FIFO_AW          3
`define FRM_W            122

`endif

// File: verilog/oam_frame_fifo.v
// small synchronous fifo for frame descriptors
// assumes one clock and a synchronous active low reset
module oam_frame_fifo #(
    parameter WIDTH = 8,
    parameter DEPTH = 8,
    parameter AW    = 3
) (
    input  wire             ref_clk,
    input  wire             reset_n,
    input  wire             in_valid,
    output wire             in_ready,
    input  wire [WIDTH-1:0] in_data,
    output wire             out_valid,
    input  wire             out_ready,
    output wire [WIDTH-1:0] out_data
);
    reg [WIDTH-1:0] mem_r [0:DEPTH-1];
    reg [AW-1:0]    wr_r;
    reg [AW-1:0]    rd_r;
    reg [AW:0]      cnt_r;
    wire            push;
    wire            pop;

    assign in_ready  = (cnt_r != DEPTH);
    assign out_valid = (cnt_r != 0);
    assign out_data  = mem_r[rd_r];
    assign push      = in_valid && in_ready;
    assign pop       = out_valid && out_ready;

    always @(posedge ref_clk) begin
        if (push) begin
            mem_r[wr_r] <= in_data;
        end
    end

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            wr_r  <= {AW{1'b0}};
            rd_r  <= {AW{1'b0}};
            cnt_r <= {(AW+1){1'b0}};
        end else begin
            if (push) begin
                wr_r <= (wr_r == DEPTH-1) ? {AW{1'b0}} : wr_r + 1'b1;
            end
            if (pop) begin
                rd_r <= (rd_r == DEPTH-1) ? {AW{1'b0}} : rd_r + 1'b1;
            end
            cnt_r <= cnt_r + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
        end
    end
endmodule

// File: verilog/oam_endpoint.v
// oam endpoint frame handling: level filter, data block, looping, counters
// assumes frame descriptors arrive from pipeline logic on ref_clk, one per cycle
`include "oam_endpoint_regs.vh"

module oam_endpoint (
    input  wire         ref_clk,
    input  wire         reset_n,
    // configuration
    input  wire         endpoint_enable,
    input  wire [2:0]   endpoint_level,
    input  wire         up_facing_select,
    input  wire         rx_dest_mac_check_sel,
    input  wire         rx_level_above_discard_en,
    input  wire         level_above_cpu_copy,
    input  wire         rx_data_block_en,
    input  wire         tx_data_block_en,
    input  wire [4:0]   loop_en,
    input  wire [11:0]  loop_service_index,
    input  wire         loop_drop_prec_clear,
    input  wire         loop_egress_index_en,
    input  wire [15:0]  uc_mac_upper,
    input  wire [31:0]  uc_mac_lower,
    input  wire [15:0]  mc_mac_upper,
    input  wire [31:0]  mc_mac_lower,
    input  wire [7:0]   sel_tx_opcode,
    input  wire [7:0]   sel_rx_opcode,
    input  wire         per_class_loopback_seq_en,
    input  wire         per_class_continuity_seq_en,
    input  wire [4:0]   per_class_counter_set_sel,
    input  wire         level_above_flag_clear,
    // frame descriptor in
    input  wire         frm_valid,
    output wire         frm_ready,
    input  wire         frm_tx,
    input  wire         frm_is_oam,
    input  wire [2:0]   frm_level,
    input  wire [7:0]   frm_opcode,
    input  wire [47:0]  frm_dmac,
    input  wire [47:0]  frm_smac,
    input  wire [2:0]   frm_class,
    input  wire [11:0]  frm_service_index,
    input  wire         frm_drop_prec,
    input  wire         frm_egress_index_en,
    // frame verdict
    output reg          verdict_valid,
    output reg          verdict_pass,
    output reg          verdict_cpu_copy,
    output reg  [31:0]  verdict_seq,
    // looped response out
    output wire         rsp_valid,
    input  wire         rsp_ready,
    output wire         rsp_via_loopback_unit,
    output wire [7:0]   rsp_opcode,
    output wire [47:0]  rsp_dmac,
    output wire [47:0]  rsp_smac,
    output wire [11:0]  rsp_service_index,
    output wire         rsp_drop_prec,
    output wire         rsp_egress_index_en,
    output wire [2:0]   rsp_class,
    // status
    output reg          level_above_drop_flag,
    output reg  [31:0]  rx_discard_counter,
    output reg  [31:0]  tx_discard_counter,
    output reg  [31:0]  rx_sel_counter,
    output reg  [31:0]  rx_nonsel_counter,
    output reg  [31:0]  tx_sel_counter,
    output reg  [31:0]  tx_nonsel_counter
);
    // ----------------------------------------
    // functions
    // ----------------------------------------
    function [7:0] rsp_op;
        input [7:0] op;
        begin
            case (op)
                `OP_LBM: rsp_op = `OP_LBR;
                `OP_LMM: rsp_op = `OP_LMR;
                `OP_DMM: rsp_op = `OP_DMR;
                `OP_SLM: rsp_op = `OP_SLR;
                default: rsp_op = op;
            endcase
        end
    endfunction

    function seq_pdu;
        input [7:0] op;
        begin
            seq_pdu = (op == `OP_TST) || (op == `OP_LBM) || (op == `OP_LBR) ||
                      (op == `OP_CCM) || (op == `OP_SAMSEQ);
        end
    endfunction

    function [31:0] inc;
        input [31:0] v;
        begin
            inc = v + `CNT_ONE;
        end
    endfunction

    // ----------------------------------------
    // classification
    // ----------------------------------------
    wire        fire;
    wire        fifo_in_ready;
    wire        level_above;
    wire        level_below;
    wire        dmac_ok;
    wire        oam_valid;
    wire        level_drop;
    wire        block_drop;
    wire        loop_hit;
    wire        loop_req;
    wire [47:0] uc_mac;
    wire [47:0] mc_mac;
    wire        seq_hit;
    wire        per_class;
    wire        level_above_drop_flag_clear_w;

    // stall input while the loop fifo is full so no response is lost
    assign frm_ready   = fifo_in_ready;
    assign fire        = frm_valid && frm_ready && endpoint_enable;
    assign uc_mac      = {uc_mac_upper, uc_mac_lower};
    assign mc_mac      = {mc_mac_upper, mc_mac_lower};
    assign level_above = frm_is_oam && (frm_level > endpoint_level);
    assign level_below = frm_is_oam && (frm_level < endpoint_level);
    assign dmac_ok     = frm_tx || (frm_dmac == (rx_dest_mac_check_sel ? uc_mac : mc_mac));
    assign oam_valid   = frm_is_oam && (frm_level == endpoint_level) && dmac_ok;
    assign level_drop  = !frm_tx && rx_level_above_discard_en && level_above;
    assign block_drop  = (frm_tx ? tx_data_block_en : rx_data_block_en) && !oam_valid
                         && !level_drop;
    assign loop_hit    = frm_is_oam ?
                         ((frm_opcode == `OP_LBM) && loop_en[`LOOP_BIT_LB]) ||
                         ((frm_opcode == `OP_LMM) && loop_en[`LOOP_BIT_LM]) ||
                         ((frm_opcode == `OP_DMM) && loop_en[`LOOP_BIT_DM]) ||
                         ((frm_opcode == `OP_SLM) && loop_en[`LOOP_BIT_SL]) :
                         loop_en[`LOOP_BIT_NON];
    assign loop_req    = fire && !frm_tx && loop_hit && (oam_valid || !frm_is_oam)
                         && !block_drop;
    assign seq_hit     = fire && frm_tx && frm_is_oam && seq_pdu(frm_opcode);
    // the two per-class flags are exclusive by software contract
    assign per_class   = per_class_loopback_seq_en || per_class_continuity_seq_en;

    // ----------------------------------------
    // loop response buffer
    // ----------------------------------------
    wire [`FRM_W-1:0] rsp_in;
    wire [`FRM_W-1:0] rsp_out;

    assign rsp_in = {up_facing_select,
                     rsp_op(frm_opcode),
                     frm_smac, uc_mac,
                     loop_service_index,
                     frm_drop_prec && !loop_drop_prec_clear,
                     frm_egress_index_en || loop_egress_index_en,
                     frm_class};

    oam_frame_fifo #(
        .WIDTH (`FRM_W),
        .DEPTH (`FIFO_DEPTH),
        .AW    (`FIFO_AW)
    ) u_rsp_fifo (
        .ref_clk   (ref_clk),
        .reset_n   (reset_n),
        .in_valid  (loop_req),
        .in_ready  (fifo_in_ready),
        .in_data   (rsp_in),
        .out_valid (rsp_valid),
        .out_ready (rsp_ready),
        .out_data  (rsp_out)
    );

    assign {rsp_via_loopback_unit, rsp_opcode, rsp_dmac, rsp_smac, rsp_service_index,
            rsp_drop_prec, rsp_egress_index_en, rsp_class} = rsp_out;

    // ----------------------------------------
    // sequence numbering
    // ----------------------------------------
    reg [31:0] seq_common_r;
    reg [31:0] class_seq_r [0:`CLASS_SETS*7-1];
    wire [7:0] set_idx;

    assign set_idx = {per_class_counter_set_sel, 3'h0} - {3'h0, per_class_counter_set_sel}
                     + {5'h0, frm_class};

    always @(posedge ref_clk) begin
        if (seq_hit && per_class && (frm_class != `CLASS_OWN)) begin
            class_seq_r[set_idx] <= inc(class_seq_r[set_idx]);
        end
    end

    always @(posedge ref_clk) begin
        if (!reset_n) begin
            seq_common_r <= `CNT_ZERO;
        end else if (seq_hit && (!per_class || frm_class == `CLASS_OWN)) begin
            seq_common_r <= inc(seq_common_r);
        end
    end

    // ----------------------------------------
    // verdicts, flags, counters
    // ----------------------------------------
    always @(posedge ref_clk) begin
        if (!reset_n) begin
            verdict_valid         <= 1'b0;
            verdict_pass          <= 1'b0;
            verdict_cpu_copy      <= 1'b0;
            verdict_seq           <= `CNT_ZERO;
            level_above_drop_flag <= 1'b0;
            rx_discard_counter    <= `CNT_ZERO;
            tx_discard_counter    <= `CNT_ZERO;
            rx_sel_counter        <= `CNT_ZERO;
            rx_nonsel_counter     <= `CNT_ZERO;
            tx_sel_counter        <= `CNT_ZERO;
            tx_nonsel_counter     <= `CNT_ZERO;
        end else begin
            verdict_valid    <= frm_valid && frm_ready;
            // disabled endpoint passes frames untouched
            verdict_pass     <= !fire || !(level_drop || block_drop || loop_req ||
                                (!frm_tx && level_below) || (frm_is_oam && !dmac_ok));
            verdict_cpu_copy <= fire && level_drop && level_above_cpu_copy;
            verdict_seq      <= (per_class && frm_class != `CLASS_OWN) ?
                                class_seq_r[set_idx] : seq_common_r;
            // set wins over clear
            if (fire && level_drop) begin
                level_above_drop_flag <= 1'b1;
            end else if (level_above_drop_flag_clear_w) begin
                level_above_drop_flag <= 1'b0;
            end
            if (fire && !frm_tx && (level_drop || block_drop)) begin
                rx_discard_counter <= inc(rx_discard_counter);
            end
            if (fire && frm_tx && block_drop) begin
                tx_discard_counter <= inc(tx_discard_counter);
            end
            if (fire && oam_valid && !frm_tx) begin
                if (frm_opcode == sel_rx_opcode) begin
                    rx_sel_counter <= inc(rx_sel_counter);
                end else begin
                    rx_nonsel_counter <= inc(rx_nonsel_counter);
                end
            end
            if (fire && frm_is_oam && frm_tx && !block_drop) begin
                if (frm_opcode == sel_tx_opcode) begin
                    tx_sel_counter <= inc(tx_sel_counter);
                end else begin
                    tx_nonsel_counter <= inc(tx_nonsel_counter);
                end
            end
        end
    end

    assign level_above_drop_flag_clear_w = level_above_flag_clear;
endmodule

// File: tb/oam_endpoint_asserts.sv
// port checker for the oam endpoint frame handler
// assumes binding onto oam_endpoint, loop and mac settings steady
module oam_endpoint_asserts (
    input logic        ref_clk,
    input logic        reset_n,
    input logic        endpoint_enable,
    input logic [2:0]  endpoint_level,
    input logic        rx_level_above_discard_en,
    input logic        tx_data_block_en,
    input logic [11:0] loop_service_index,
    input logic [15:0] uc_mac_upper,
    input logic [31:0] uc_mac_lower,
    input logic        level_above_flag_clear,
    input logic        frm_valid,
    input logic        frm_ready,
    input logic        frm_tx,
    input logic        frm_is_oam,
    input logic [2:0]  frm_level,
    input logic        verdict_pass,
    input logic        rsp_valid,
    input logic        rsp_ready,
    input logic [7:0]  rsp_opcode,
    input logic [47:0] rsp_smac,
    input logic [11:0] rsp_service_index,
    input logic        level_above_drop_flag,
    input logic [31:0] rx_discard_counter,
    input logic [31:0] tx_discard_counter
);
    timeunit 1ns;
    timeprecision 1ps;
    logic acc;
    logic hi;
    assign acc = frm_valid && frm_ready && endpoint_enable;
    assign hi = acc && !frm_tx && frm_is_oam && rx_level_above_discard_en
                && (frm_level > endpoint_level);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!reset_n);
    property p_high_drop;
        hi |=> level_above_drop_flag && !verdict_pass;
    endproperty
    a_high_drop: assert property (p_high_drop) else $error("high level frame kept");
    property p_high_count;
        hi |=> rx_discard_counter == $past(rx_discard_counter) + 32'h1;
    endproperty
    a_high_count: assert property (p_high_count) else $error("rx discard miscount");
    property p_sticky;
        level_above_drop_flag && !level_above_flag_clear |=> level_above_drop_flag;
    endproperty
    a_sticky: assert property (p_sticky) else $error("flag lost");
    property p_off;
        frm_valid && frm_ready && !endpoint_enable |=> verdict_pass
            && $stable(rx_discard_counter) && $stable(tx_discard_counter);
    endproperty
    a_off: assert property (p_off) else $error("disabled endpoint acted");
    property p_tx_block;
        acc && frm_tx && tx_data_block_en && !frm_is_oam |=> !verdict_pass
            && tx_discard_counter == $past(tx_discard_counter) + 32'h1;
    endproperty
    a_tx_block: assert property (p_tx_block) else $error("tx block failed");
    property p_rsp_hold;
        rsp_valid && !rsp_ready |=> rsp_valid && $stable(rsp_opcode);
    endproperty
    a_rsp_hold: assert property (p_rsp_hold) else $error("response dropped");
    property p_rsp_smac;
        rsp_valid |-> rsp_smac == {uc_mac_upper, uc_mac_lower};
    endproperty
    a_rsp_smac: assert property (p_rsp_smac) else $error("bad response source");
    property p_rsp_index;
        rsp_valid |-> rsp_service_index == loop_service_index;
    endproperty
    a_rsp_index: assert property (p_rsp_index) else $error("bad response index");
endmodule

// File: tb/oam_pipeline_model.sv
// sink model of the switch path that takes looped responses
// assumes the bench steers stalls through hold_off off the clock edge
module oam_pipeline_model (
    input  logic       ref_clk,
    input  logic       reset_n,
    input  logic       hold_off,
    input  logic       rsp_valid,
    output logic       rsp_ready,
    output logic [7:0] pops
);
    timeunit 1ns;
    timeprecision 1ps;
    // stalls are the only misbehaviour the bench asks for
    assign rsp_ready = !hold_off;
    always @(posedge ref_clk) begin
        if (!reset_n)
            pops <= 8'h00;
        else if (rsp_valid && rsp_ready)
            pops <= pops + 8'h01;
    end
endmodule

// File: tb/test_oam_endpoint.sv
// self-checking bench for the oam endpoint frame handler
// assumes design, sink model and checker compiled ahead of it
`include "oam_endpoint_regs.vh"
module test_oam_endpoint;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [47:0] UC = 48'h0a1b_2c3d_4e5f;
    localparam logic [47:0] SRC = 48'h0200_0000_0042;
    logic        ref_clk, reset_n, endpoint_enable, up_facing_select, rx_dest_mac_check_sel;
    logic        rx_level_above_discard_en, level_above_cpu_copy, rx_data_block_en;
    logic        tx_data_block_en, loop_drop_prec_clear, loop_egress_index_en, hold_off;
    logic        per_class_loopback_seq_en, per_class_continuity_seq_en, level_above_flag_clear;
    logic        frm_valid, frm_ready, frm_tx, frm_is_oam, frm_drop_prec, frm_egress_index_en;
    logic        verdict_valid, verdict_pass, verdict_cpu_copy, rsp_valid, rsp_ready;
    logic        rsp_via_loopback_unit, rsp_drop_prec, rsp_egress_index_en, level_above_drop_flag;
    logic        vpass, vcpu;
    logic [2:0]  endpoint_level, frm_level, frm_class, rsp_class;
    logic [4:0]  loop_en, per_class_counter_set_sel;
    logic [7:0]  sel_tx_opcode, sel_rx_opcode, frm_opcode, rsp_opcode, pops;
    logic [11:0] loop_service_index, frm_service_index, rsp_service_index;
    logic [15:0] uc_mac_upper, mc_mac_upper;
    logic [31:0] uc_mac_lower, mc_mac_lower, verdict_seq, rx_discard_counter, tx_discard_counter;
    logic [31:0] rx_sel_counter, rx_nonsel_counter, tx_sel_counter, tx_nonsel_counter, d, e, s;
    logic [47:0] frm_dmac, frm_smac, rsp_dmac, rsp_smac;
    integer      mismatches, checks_done;
    oam_endpoint i_oam_endpoint (.*);
    oam_pipeline_model i_oam_pipeline_model (.*);
    initial begin
        ref_clk = 1'b0;
        forever #2.5 ref_clk = ~ref_clk;
    end
    task automatic chk(input logic [47:0] got, input logic [47:0] exp);
        checks_done = checks_done + 1;
        if (got !== exp) begin
            mismatches = mismatches + 1;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic conclude;
        $display("mismatches %0d checks_done %0d", mismatches, checks_done);
        if (mismatches == 0 && checks_done > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // starts a negedge late so frm_valid never moves twice in one step
    task automatic send(input logic tx, input logic oam, input logic [2:0] lvl,
                        input logic [7:0] op);
        integer n;
        @(negedge ref_clk);
        {frm_tx, frm_is_oam, frm_level, frm_opcode} = {tx, oam, lvl, op};
        frm_valid = 1'b1;
        n = 0;
        while (frm_ready !== 1'b1 && n < 50) begin
            @(negedge ref_clk);
            n = n + 1;
        end
        if (n == 50) begin
            mismatches = mismatches + 1;
            conclude();
        end
        @(negedge ref_clk);
        frm_valid = 1'b0;
        vpass = verdict_pass;
        vcpu = verdict_cpu_copy;
        chk(verdict_valid, 1'b1);
    endtask
    task automatic t_loop;
        logic [7:0] msg [4];
        logic [7:0] rsp [4];
        msg = '{`OP_LBM, `OP_LMM, `OP_DMM, `OP_SLM};
        rsp = '{`OP_LBR, `OP_LMR, `OP_DMR, `OP_SLR};
        for (int i = 0; i < 4; i++) begin
            up_facing_select = i[0];
            send(1'b0, 1'b1, 3'h4, msg[i]);
            chk(vpass, 1'b0);
            chk(rsp_opcode, rsp[i]);
            chk(rsp_dmac, SRC);
            chk(rsp_via_loopback_unit, i[0]);
            chk({rsp_drop_prec, rsp_egress_index_en, rsp_class}, 5'h0b);
        end
        send(1'b0, 1'b0, 3'h0, 8'h00);
        chk(rsp_valid, 1'b1);
        loop_en = 5'h1e;
        send(1'b0, 1'b1, 3'h4, `OP_LBM);
        chk(rsp_valid, 1'b0);
    endtask
    task automatic t_level;
        d = rx_discard_counter;
        rx_level_above_discard_en = 1'b1;
        send(1'b0, 1'b1, 3'h6, `OP_TST);
        chk({vpass, vcpu}, 2'b01);
        chk(rx_discard_counter, d + 32'h1);
        repeat (3) @(negedge ref_clk);
        chk(level_above_drop_flag, 1'b1);
        level_above_flag_clear = 1'b1;
        @(negedge ref_clk);
        level_above_flag_clear = 1'b0;
        chk(level_above_drop_flag, 1'b0);
    endtask
    task automatic t_block;
        {d, e} = {rx_discard_counter, tx_discard_counter};
        {loop_en, tx_data_block_en, rx_data_block_en} = 7'h03;
        send(1'b1, 1'b0, 3'h0, 8'h00);
        chk({vpass, tx_discard_counter}, {1'b0, e + 32'h1});
        send(1'b0, 1'b0, 3'h0, 8'h00);
        chk({vpass, rx_discard_counter}, {1'b0, d + 32'h1});
        send(1'b1, 1'b1, 3'h4, `OP_TST);
        chk(vpass, 1'b1);
        {tx_data_block_en, rx_data_block_en} = 2'b00;
        {d, e} = {tx_sel_counter, tx_nonsel_counter};
        send(1'b1, 1'b1, 3'h4, `OP_TST);
        s = verdict_seq;
        send(1'b1, 1'b1, 3'h4, `OP_CCM);
        chk(verdict_seq, s + 32'h1);
        chk({tx_sel_counter, tx_nonsel_counter}, {d + 32'h1, e + 32'h1});
        endpoint_enable = 1'b0;
        {d, e} = {rx_discard_counter, rx_sel_counter + rx_nonsel_counter};
        send(1'b0, 1'b1, 3'h6, `OP_LBM);
        chk({vpass, rsp_valid}, 2'b10);
        chk(rx_sel_counter + rx_nonsel_counter, e);
        endpoint_enable = 1'b1;
    endtask
    task automatic t_fifo;
        loop_en = 5'h1f;
        hold_off = 1'b1;
        d = {24'h0, pops};
        repeat (8) send(1'b0, 1'b1, 3'h4, `OP_LBM);
        chk(frm_ready, 1'b0);
        hold_off = 1'b0;
        repeat (12) @(negedge ref_clk);
        chk(pops, d[7:0] + 8'h08);
        chk(rsp_valid, 1'b0);
    endtask
    initial begin
        {mismatches, checks_done} = 0;
        {reset_n, hold_off, frm_valid, level_above_flag_clear} = 4'h0;
        {endpoint_enable, rx_dest_mac_check_sel, level_above_cpu_copy} = 3'h7;
        {up_facing_select, rx_level_above_discard_en, rx_data_block_en} = 3'h0;
        {tx_data_block_en, frm_egress_index_en} = 2'b00;
        {loop_drop_prec_clear, loop_egress_index_en, frm_drop_prec} = 3'h7;
        {per_class_loopback_seq_en, per_class_continuity_seq_en} = 2'b00;
        per_class_counter_set_sel = 5'h03;
        {endpoint_level, frm_class, loop_en, loop_service_index} = {6'h23, 5'h1f, 12'h5a5};
        {frm_tx, frm_is_oam, frm_level, frm_opcode} = 13'h0;
        {sel_tx_opcode, sel_rx_opcode} = {`OP_TST, `OP_LBM};
        {uc_mac_upper, uc_mac_lower, frm_dmac, frm_smac} = {UC, UC, SRC};
        {mc_mac_upper, mc_mac_lower, frm_service_index} = {48'h0180_c200_0030, 12'h011};
        repeat (8) @(negedge ref_clk);
        reset_n = 1'b1;
        chk({frm_ready, rsp_valid, rx_discard_counter}, {2'b10, 32'h0});
        t_loop();
        t_level();
        t_block();
        t_fifo();
        conclude();
    end
endmodule
bind oam_endpoint oam_endpoint_asserts i_oam_endpoint_asserts (.*);
